// >>> include/mis_defines.vh
// Constants for the motor identification sequencer: APB offsets, field layouts,
// display codes, identification modes and progress codes.
// Assumes inclusion by bare name from the rtl files.
`ifndef MIS_DEFINES_VH
`define MIS_DEFINES_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define MIS_OFF_IDENT_SELECT 8'h00
`define MIS_OFF_STATUS 8'h04
`define MIS_OFF_INT_STATUS 8'h08
`define MIS_OFF_INT_MASK 8'h0C
`define MIS_OFF_RAMP_TIME 8'h10
`define MIS_OFF_MAX_SPEED 8'h14

// ------------------------------------------------------------
// Field widths and reset values
// ------------------------------------------------------------
`define MIS_SEL_W 5
`define MIS_SEL_RESET 5'h00
`define MIS_RAMP_RESET 16'h0064
`define MIS_SPEED_RESET 16'h0400
`define MIS_INT_W 3
`define MIS_INT_DONE 0
`define MIS_INT_ERROR 1
`define MIS_INT_REJECT 2

// ------------------------------------------------------------
// Identification select values
// ------------------------------------------------------------
`define MIS_SEL_OFF 5'h00
`define MIS_SEL_AUTO_STILL 5'h07
`define MIS_SEL_AUTO_MOVE 5'h08

// ------------------------------------------------------------
// Inverter states seen on the state input
// ------------------------------------------------------------
`define MIS_INV_STOP 2'h0
`define MIS_INV_NOOP 2'h1

// ------------------------------------------------------------
// Drive state display codes
// ------------------------------------------------------------
`define MIS_DISP_CALC 8'h52
`define MIS_DISP_READY 8'h7F
`define MIS_DISP_ERROR 8'h3C

// ------------------------------------------------------------
// Progress codes (also sequencer state codes)
// ------------------------------------------------------------
`define MIS_ST_IDLE 4'h0
`define MIS_ST_ARMED 4'h1
`define MIS_ST_DEADTIME 4'h2
`define MIS_ST_STATOR 4'h3
`define MIS_ST_ROTOR 4'h4
`define MIS_ST_LEAKAGE 4'h5
`define MIS_ST_ACCEL 4'h6
`define MIS_ST_MAININD 4'h7
`define MIS_ST_DECEL 4'h8
`define MIS_ST_DONE 4'h9
`define MIS_ST_ERROR 4'hA

`endif

// >>> rtl/mis_motor_ident_sequencer.v
// Motor identification sequencer with APB register access.
// Assumes an external measurement engine that pulses i_step_done or
// i_step_error for each standstill or main inductance step, APB inputs
// synchronous to i_clk, and inverter state from the drive control.
//
// Function
// - Select writes accepted only in stop/no-operation
// - Write in stop starts measurement automatically
// - Write in no-operation waits for control release
// - Show code 82 while measuring
// - Show code 127 after success
// - Show code 60 after error interruption
// - Current step shown in progress output
// - Stay in mode until release removed
// - New run only after fresh select write
// - Brake release held off during identification
// - Main inductance run always forward
// - Select decodes 0 off, 7 still, 8 move
// - Standstill steps: deadtime, stator, rotor, leakage
// - Accelerate to max torque speed, run unloaded
// - Identification ramp time for accel and decel
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "mis_defines.vh"

module mis_motor_ident_sequencer #(
  parameter SPEED_W = 16
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire [1:0] i_inverter_state,
  input wire i_control_release,
  input wire [7:0] i_base_state_code,
  input wire i_step_done,
  input wire i_step_error,
  input wire i_brake_request,
  input wire i_dir_forward,
  input wire [SPEED_W-1:0] i_speed_setpoint,
  output reg [7:0] o_drive_state_display,
  output reg [3:0] o_ident_progress_state,
  output reg o_meas_run,
  output reg o_ident_active,
  output reg o_brake_release,
  output reg o_dir_forward,
  output reg [SPEED_W-1:0] o_speed_setpoint,
  output reg o_irq
);

  // ------------------------------------------------------------
  // Sequencer states, coded as the progress values
  // ------------------------------------------------------------
  localparam [3:0] ST_IDLE = `MIS_ST_IDLE;
  localparam [3:0] ST_ARMED = `MIS_ST_ARMED;
  localparam [3:0] ST_DEADTIME = `MIS_ST_DEADTIME;
  localparam [3:0] ST_STATOR = `MIS_ST_STATOR;
  localparam [3:0] ST_ROTOR = `MIS_ST_ROTOR;
  localparam [3:0] ST_LEAKAGE = `MIS_ST_LEAKAGE;
  localparam [3:0] ST_ACCEL = `MIS_ST_ACCEL;
  localparam [3:0] ST_MAININD = `MIS_ST_MAININD;
  localparam [3:0] ST_DECEL = `MIS_ST_DECEL;
  localparam [3:0] ST_DONE = `MIS_ST_DONE;
  localparam [3:0] ST_ERROR = `MIS_ST_ERROR;

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  reg [`MIS_SEL_W-1:0] ident_select;
  reg [15:0] ident_ramp_time;
  reg [SPEED_W-1:0] max_torque_speed;
  reg [`MIS_INT_W-1:0] int_status;
  reg [`MIS_INT_W-1:0] int_mask;
  reg start_pending;
  reg with_move;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [15:0] ramp_cnt;
  reg [SPEED_W-1:0] ramp_speed;
  reg [1:0] last_result;

  wire setup = i_psel & ~i_penable;
  wire wr_now = i_psel & i_penable & o_pready & i_pwrite;
  wire state_ok = (i_inverter_state == `MIS_INV_STOP) || (i_inverter_state == `MIS_INV_NOOP);
  wire sel_hit = (i_paddr == `MIS_OFF_IDENT_SELECT);
  wire sel_wr = wr_now & sel_hit;
  wire sel_accept = sel_wr & state_ok;
  wire sel_reject = sel_wr & ~state_ok;
  wire [`MIS_SEL_W-1:0] sel_val = i_pwdata[`MIS_SEL_W-1:0];
  wire sel_start = (sel_val == `MIS_SEL_AUTO_STILL) || (sel_val == `MIS_SEL_AUTO_MOVE);
  wire ramp_tick = (ramp_cnt == 16'h0000);

  reg ev_done;
  reg ev_error;

  // ------------------------------------------------------------
  // Address and state decode helpers
  // ------------------------------------------------------------
  function mis_mapped;
    input [7:0] addr;
    begin
      mis_mapped = (addr == `MIS_OFF_IDENT_SELECT) || (addr == `MIS_OFF_STATUS) ||
        (addr == `MIS_OFF_INT_STATUS) || (addr == `MIS_OFF_INT_MASK) ||
        (addr == `MIS_OFF_RAMP_TIME) || (addr == `MIS_OFF_MAX_SPEED);
    end
  endfunction

  function mis_measuring;
    input [3:0] st;
    begin
      mis_measuring = (st == ST_DEADTIME) || (st == ST_STATOR) ||
        (st == ST_ROTOR) || (st == ST_LEAKAGE) || (st == ST_MAININD);
    end
  endfunction

  // ------------------------------------------------------------
  // APB slave: no wait states, registered answer
  // ------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end
    else
    begin
      o_pready <= setup;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      if (setup)
      begin
        // Refusal is judged at setup; the inverter state must hold through access
        if (!mis_mapped(i_paddr))
          o_pslverr <= 1'b1;
        else if (i_pwrite && sel_hit && !state_ok)
          o_pslverr <= 1'b1;
        if (!i_pwrite)
        begin
          case (i_paddr)
            `MIS_OFF_IDENT_SELECT: o_prdata <= {27'h0000000, ident_select};
            `MIS_OFF_STATUS: o_prdata <= {16'h0000, last_result, start_pending, o_ident_active,
              o_ident_progress_state, o_drive_state_display};
            `MIS_OFF_INT_STATUS: o_prdata <= {29'h00000000, int_status};
            `MIS_OFF_INT_MASK: o_prdata <= {29'h00000000, int_mask};
            `MIS_OFF_RAMP_TIME: o_prdata <= {16'h0000, ident_ramp_time};
            `MIS_OFF_MAX_SPEED: o_prdata <= {{(32-SPEED_W){1'b0}}, max_torque_speed};
            default: o_prdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ident_select <= `MIS_SEL_RESET;
      ident_ramp_time <= `MIS_RAMP_RESET;
      max_torque_speed <= `MIS_SPEED_RESET;
      int_mask <= 3'h0;
    end
    else
    begin
      if (sel_accept)
        ident_select <= sel_val;
      if (wr_now && i_paddr == `MIS_OFF_RAMP_TIME)
        ident_ramp_time <= i_pwdata[15:0];
      if (wr_now && i_paddr == `MIS_OFF_MAX_SPEED)
        max_torque_speed <= i_pwdata[SPEED_W-1:0];
      if (wr_now && i_paddr == `MIS_OFF_INT_MASK)
        int_mask <= i_pwdata[`MIS_INT_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Interrupt status: set wins over write-one-to-clear
  // ------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      int_status <= 3'h0;
      o_irq <= 1'b0;
    end
    else
    begin
      int_status <= (int_status & ~((wr_now && i_paddr == `MIS_OFF_INT_STATUS) ?
        i_pwdata[`MIS_INT_W-1:0] : 3'h0)) | {sel_reject, ev_error, ev_done};
      o_irq <= |(int_status & int_mask);
    end
  end

  // ------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------
  always @*
  begin
    next_state = state;
    ev_done = 1'b0;
    ev_error = 1'b0;
    case (state)
      ST_IDLE:
        if (start_pending)
        begin
          if (i_inverter_state == `MIS_INV_STOP)
            next_state = ST_DEADTIME;
          else
            next_state = ST_ARMED;
        end
      // Deferred start waits here for control release
      ST_ARMED:
        if (!start_pending)
          next_state = ST_IDLE;
        else if (i_control_release)
          next_state = ST_DEADTIME;
      ST_DEADTIME, ST_STATOR, ST_ROTOR, ST_LEAKAGE, ST_MAININD:
        if (i_step_error)
        begin
          next_state = ST_ERROR;
          ev_error = 1'b1;
        end
        else if (i_step_done)
        begin
          case (state)
            ST_DEADTIME: next_state = ST_STATOR;
            ST_STATOR: next_state = ST_ROTOR;
            ST_ROTOR: next_state = ST_LEAKAGE;
            ST_LEAKAGE: next_state = with_move ? ST_ACCEL : ST_DONE;
            default: next_state = ST_DECEL;
          endcase
          if (state == ST_LEAKAGE && !with_move)
            ev_done = 1'b1;
        end
      ST_ACCEL:
        if (i_step_error)
        begin
          next_state = ST_ERROR;
          ev_error = 1'b1;
        end
        else if (ramp_speed == max_torque_speed)
          next_state = ST_MAININD;
      ST_DECEL:
        if (i_step_error)
        begin
          next_state = ST_ERROR;
          ev_error = 1'b1;
        end
        else if (ramp_speed == {SPEED_W{1'b0}})
        begin
          next_state = ST_DONE;
          ev_done = 1'b1;
        end
      ST_DONE, ST_ERROR:
        if (!i_control_release)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
    // Losing release mid-run is an interruption
    if ((mis_measuring(state) || state == ST_ACCEL || state == ST_DECEL) && !i_control_release)
    begin
      next_state = ST_ERROR;
      ev_error = 1'b1;
      ev_done = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Sequencer state, start latch and ramp
  // ------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state <= ST_IDLE;
      start_pending <= 1'b0;
      with_move <= 1'b0;
      ramp_cnt <= 16'h0000;
      ramp_speed <= {SPEED_W{1'b0}};
      last_result <= 2'h0;
    end
    else
    begin
      state <= next_state;
      // An accepted 7 or 8 write arms a run; entering the first step consumes it
      if (sel_accept)
      begin
        start_pending <= sel_start;
        with_move <= (sel_val == `MIS_SEL_AUTO_MOVE);
      end
      else if (next_state == ST_DEADTIME)
        start_pending <= 1'b0;
      if (ev_done)
        last_result <= 2'h1;
      else if (ev_error)
        last_result <= 2'h2;
      else if (sel_accept)
        last_result <= 2'h0;
      // One speed step every ramp time plus one cycles
      if (state == ST_ACCEL || state == ST_DECEL)
      begin
        ramp_cnt <= ramp_tick ? ident_ramp_time : ramp_cnt - 16'h0001;
        if (ramp_tick && state == ST_ACCEL && ramp_speed != max_torque_speed)
          ramp_speed <= ramp_speed + {{(SPEED_W-1){1'b0}}, 1'b1};
        if (ramp_tick && state == ST_DECEL && ramp_speed != {SPEED_W{1'b0}})
          ramp_speed <= ramp_speed - {{(SPEED_W-1){1'b0}}, 1'b1};
      end
      else if (state != ST_MAININD)
      begin
        ramp_cnt <= ident_ramp_time;
        ramp_speed <= {SPEED_W{1'b0}};
      end
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_drive_state_display <= 8'h00;
      o_ident_progress_state <= ST_IDLE;
      o_meas_run <= 1'b0;
      o_ident_active <= 1'b0;
      o_brake_release <= 1'b0;
      o_dir_forward <= 1'b0;
      o_speed_setpoint <= {SPEED_W{1'b0}};
    end
    else
    begin
      o_ident_progress_state <= next_state;
      o_meas_run <= mis_measuring(next_state);
      o_ident_active <= (next_state != ST_IDLE) && (next_state != ST_ARMED);
      case (next_state)
        ST_IDLE, ST_ARMED: o_drive_state_display <= i_base_state_code;
        ST_DONE: o_drive_state_display <= `MIS_DISP_READY;
        ST_ERROR: o_drive_state_display <= `MIS_DISP_ERROR;
        default: o_drive_state_display <= `MIS_DISP_CALC;
      endcase
      // Outside identification the normal-operation values pass through
      if (next_state == ST_IDLE || next_state == ST_ARMED)
      begin
        o_brake_release <= i_brake_request;
        o_dir_forward <= i_dir_forward;
        o_speed_setpoint <= i_speed_setpoint;
      end
      else
      begin
        o_brake_release <= 1'b0;
        o_dir_forward <= 1'b1;
        o_speed_setpoint <= (next_state == ST_DONE || next_state == ST_ERROR) ?
          {SPEED_W{1'b0}} : ramp_speed;
      end
    end
  end

endmodule // mis_motor_ident_sequencer

// >>> test/mis_engine_model.sv
// Measurement engine and motor stand-in for the identification sequencer.
// Assumes a delay chosen per run by the bench; pulses one result per step.
`timescale 1ns/1ps
module mis_engine_model (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_meas_run,
  input wire [3:0] i_delay,
  input wire i_fail,
  output reg o_step_done,
  output reg o_step_error
);
  reg [3:0] cnt;
  always @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      cnt <= 4'h0;
      o_step_done <= 1'b0;
      o_step_error <= 1'b0;
    end
    else
    begin
      o_step_done <= 1'b0;
      o_step_error <= 1'b0;
      if (!i_meas_run || o_step_done || o_step_error)
        cnt <= 4'h0;
      else if (cnt >= i_delay)
      begin
        cnt <= 4'h0;
        o_step_done <= !i_fail;
        o_step_error <= i_fail;
      end
      else
        cnt <= cnt + 4'h1;
    end
endmodule // mis_engine_model

// >>> test/mis_seq_checker.sv
// Port-level assertions for the identification sequencer.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ps
module mis_seq_checker (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [1:0] i_inverter_state,
  input wire i_control_release,
  input wire [7:0] o_drive_state_display,
  input wire [3:0] o_ident_progress_state,
  input wire o_meas_run,
  input wire o_ident_active,
  input wire o_brake_release,
  input wire o_dir_forward
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire [3:0] p = o_ident_progress_state;
  wire [7:0] d = o_drive_state_display;
  sequence sel_setup;
    i_psel && !i_penable && i_pwrite && i_paddr == 8'h00;
  endsequence
  sequence rej_wr;
    (sel_setup and i_inverter_state[1]) ##1 o_pready;
  endsequence
  sequence start_wr;
    (sel_setup and (i_inverter_state == 2'h0 && i_pwdata[4:0] == 5'h07 && p == 4'h0)) ##1 o_pready && !o_pslverr;
  endsequence
  rej_err_a: assert property (rej_wr |-> o_pslverr) else $error("select write not refused");
  rej_keep_a: assert property (rej_wr ##0 p == 4'h0 |-> ##2 p == 4'h0) else $error("refused write ran");
  stop_start_a: assert property (start_wr |-> ##[1:2] p == 4'h2) else $error("no self start");
  calc_code_a: assert property (o_meas_run |-> d == 8'h52) else $error("bad busy code");
  ready_code_a: assert property (p == 4'h9 |-> d == 8'h7F) else $error("bad ready code");
  error_code_a: assert property (p == 4'hA |-> d == 8'h3C) else $error("bad error code");
  brake_hold_a: assert property (o_ident_active |-> !o_brake_release) else $error("brake released");
  fwd_dir_a: assert property (p == 4'h7 |-> o_dir_forward) else $error("not forward");
  leave_mode_a: assert property ((p == 4'h9 || p == 4'hA) && !i_control_release |=> p == 4'h0)
    else $error("mode not left");
  drop_err_a: assert property (o_meas_run && !i_control_release |=> p == 4'hA) else $error("drop not error");
endmodule // mis_seq_checker
bind mis_motor_ident_sequencer mis_seq_checker u_chk (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .i_inverter_state, .i_control_release, .o_drive_state_display,
  .o_ident_progress_state, .o_meas_run, .o_ident_active, .o_brake_release, .o_dir_forward);

// >>> test/tb_motor_ident_sequencer.sv
// Self-checking bench for the identification sequencer.
// Assumes the engine model on the far side and the bound checker.
`timescale 1ns/1ps
module tb_motor_ident_sequencer;
  logic i_clk = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, er, fail_req = 0;
  logic i_control_release = 0, i_brake_request = 0, i_dir_forward = 0, o_pready, o_pslverr, o_irq;
  logic i_step_done, i_step_error, o_meas_run, o_ident_active, o_brake_release, o_dir_forward;
  logic [1:0] i_inverter_state = 0;
  logic [3:0] o_ident_progress_state, dly = 4, trace[$], exp_q[$];
  logic [7:0] i_paddr = 0, i_base_state_code = 0, o_drive_state_display, seed = 8'h09, exp_disp;
  logic [15:0] i_speed_setpoint = 0, o_speed_setpoint, last_spd = 0;
  logic [31:0] i_pwdata = 0, o_prdata, rd;
  logic [7:0] ra[5] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h64, 32'h400, 32'h0};
  integer fails = 0, check_count = 0, gap = 0, n, k;
  mis_motor_ident_sequencer u_dut (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_inverter_state, .i_control_release, .i_base_state_code, .i_step_done,
    .i_step_error, .i_brake_request, .i_dir_forward, .i_speed_setpoint, .o_drive_state_display,
    .o_ident_progress_state, .o_meas_run, .o_ident_active, .o_brake_release, .o_dir_forward,
    .o_speed_setpoint, .o_irq);
  mis_engine_model u_eng (.i_clk, .i_sys_rst, .i_meas_run(o_meas_run), .i_delay(dly), .i_fail(fail_req),
    .o_step_done(i_step_done), .o_step_error(i_step_error));
  always #5 i_clk = ~i_clk;
  assign exp_disp = o_ident_progress_state == 9 ? 8'h7F : o_ident_progress_state == 10 ? 8'h3C : 8'h52;
  function automatic [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input [31:0] seen, input [31:0] exp, input string nm);
    begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task stop_test;
    begin
      if (fails == 0 && check_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer t;
    begin
      t = 0;
      @(posedge i_clk);
      i_psel <= 1;
      i_penable <= 0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1;
      @(posedge i_clk);
      while (o_pready !== 1'b1 && t < 16)
      begin
        @(posedge i_clk);
        t = t + 1;
      end
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 0;
      i_penable <= 0;
      if (t == 16) chk(0, 1, "pready");
    end
  endtask
  // Per-cycle model of the outputs while identifying
  always @(posedge i_clk)
    if (!i_sys_rst && o_ident_active === 1'b1)
    begin
      chk(o_brake_release, 0, "brake");
      chk(o_dir_forward, 1, "dir");
      chk(o_drive_state_display, exp_disp, "disp");
      if (trace.size() == 0 || trace[$] !== o_ident_progress_state) trace.push_back(o_ident_progress_state);
      gap = gap + 1;
      if (o_ident_progress_state == 6 && o_speed_setpoint !== last_spd)
      begin
        if (last_spd != 0) chk(gap, 3, "ramp");
        gap = 0;
      end
      if (o_ident_progress_state == 7) chk(o_speed_setpoint, 4, "speed");
      last_spd = o_speed_setpoint;
    end
  task automatic run(input logic [4:0] m, input logic [1:0] inv, input logic drop, input logic [31:0] ib);
    begin
      @(posedge i_clk);
      seed = lfsr(seed);
      dly <= seed[3:0] | 4'h4;
      i_base_state_code <= seed;
      i_speed_setpoint <= {seed, ~seed};
      i_dir_forward <= seed[0];
      trace.delete();
      i_inverter_state <= inv;
      i_control_release <= (inv == 0);
      apb(1, 8'h00, m);
      chk(er, 0, "accept");
      if (inv == 1)
      begin
        repeat (4) @(posedge i_clk);
        chk(o_ident_progress_state, 1, "armed");
        i_control_release <= 1;
      end
      for (n = 0; n < 400 && !(o_ident_progress_state >= 9); n++)
      begin
        @(posedge i_clk);
        if (drop && o_ident_progress_state == 3) i_control_release <= 0;
      end
      apb(0, 8'h08, 0);
      chk(rd, ib, "int status");
      chk(o_irq, 1, "irq");
      apb(0, 8'h04, 0);
      chk(rd[15:14], ib, "result");
      apb(1, 8'h08, 7);
      i_control_release <= 0;
      repeat (2) @(posedge i_clk);
      chk(o_ident_progress_state, 0, "left");
      chk(o_irq, 0, "irq clear");
      i_control_release <= 1;
      repeat (4) @(posedge i_clk);
      chk(o_ident_progress_state, 0, "rearm");
      chk(o_drive_state_display, i_base_state_code, "base");
      chk(o_speed_setpoint, i_speed_setpoint, "pass speed");
      chk(o_dir_forward, i_dir_forward, "pass dir");
      chk(o_brake_release, 1, "pass brake");
      i_control_release <= 0;
      chk(trace.size(), exp_q.size(), "steps");
      foreach (exp_q[i]) chk(trace[i], exp_q[i], "step");
    end
  endtask
  initial
  begin
    #400000;
    fails = fails + 1;
    stop_test;
  end
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 0;
    i_brake_request <= 1;
    for (k = 0; k < 5; k++)
    begin
      apb(0, ra[k], 0);
      chk(rd, rv[k], "reset value");
      chk(er, k == 4, "unmapped");
    end
    apb(1, 8'h10, 2);
    apb(1, 8'h14, 4);
    i_inverter_state <= 2;
    apb(1, 8'h00, 7);
    chk(er, 1, "refuse");
    apb(0, 8'h00, 0);
    chk(rd, 0, "kept");
    chk(o_ident_progress_state, 0, "no start");
    chk(o_irq, 0, "masked");
    apb(1, 8'h0C, 4);
    repeat (2) @(posedge i_clk);
    chk(o_irq, 1, "reject irq");
    apb(1, 8'h08, 4);
    repeat (2) @(posedge i_clk);
    chk(o_irq, 0, "cleared");
    apb(1, 8'h0C, 7);
    i_inverter_state <= 1;
    apb(1, 8'h00, 8);
    apb(1, 8'h00, 0);
    i_control_release <= 1;
    repeat (3) @(posedge i_clk);
    chk(o_ident_progress_state, 0, "off");
    i_control_release <= 0;
    exp_q = '{2, 3, 4, 5, 9};
    run(7, 0, 0, 1);
    exp_q = '{2, 3, 4, 5, 6, 7, 8, 9};
    run(8, 1, 0, 1);
    exp_q = '{2, 3, 10};
    run(7, 0, 1, 2);
    fail_req <= 1;
    exp_q = '{2, 10};
    run(8, 0, 0, 2);
    stop_test;
  end
endmodule // tb_motor_ident_sequencer
